// ===== core/ostc_chan_seq.sv
// Per-channel trigger collection and synchronisation sequencer.
`timescale 1ns/1ps
`include "ostc_map.svh"
module ostc_chan_seq #(
    parameter int NOUT = 6
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  ostc_pkg::ostc_ctrl_t   ctrl,
    input  ostc_pkg::ostc_lock_t   lock,
    input  wire logic [NOUT-1:0]   excl,
    output logic      [NOUT-1:0]   out_mute,
    output logic      [NOUT-1:0]   div_reset,
    output ostc_pkg::ostc_state_t  state,
    output logic                   first_done,
    output logic                   armed
);
    ostc_pkg::ostc_state_t state_next;
    logic            pending_reg;
    logic            cause_reconf_reg;
    logic [1:0]      offset_cnt_reg;
    logic            auto_evt;
    logic            auto_fire;
    logic            idle;
    logic            trig;
    logic            trig_all;
    logic            pend_all_reg;
    logic            start;
    logic            release_ok;
    logic [NOUT-1:0] affected;

    assign idle = (state == ostc_pkg::ST_IDLE);

    assign auto_evt = (ctrl.mode == 2'd1) ? lock.sys_lock :
                      (ctrl.mode == 2'd2) ? lock.phase_lock :
                      (ctrl.mode == 2'd3) ? lock.freq_lock : 1'b0;
    assign auto_fire = (ctrl.mode != 2'd0) && armed && lock.sys_lock && auto_evt;

    // Manual is a level, so it may only raise pending once or the sequence would rerun.
    assign trig_all = (idle && ctrl.manual && !pending_reg) || auto_fire;
    // Reconfiguration is ignored until the first sequence has finished.
    assign trig  = trig_all || (ctrl.reconf && first_done);
    assign start = idle && pending_reg && lock.sys_lock;

    // Manual hold is honoured in both release paths so a stall is never skipped.
    assign release_ok = lock.aml_lock && !ctrl.manual &&
                        (!ctrl.refsync || (lock.ref_rise && lock.hitless));

    // Sysclk-driven masked outputs ride through reconfiguration untouched.
    assign affected = cause_reconf_reg ? ~excl : {NOUT{1'b1}};

    always_comb begin
        state_next = state;
        case (state)
            ostc_pkg::ST_IDLE:
                if (start) begin
                    state_next = ctrl.refsync ? ostc_pkg::ST_WAIT_HITLESS : ostc_pkg::ST_MUTE;
                end
            ostc_pkg::ST_WAIT_HITLESS:
                if (lock.hitless) begin
                    state_next = ostc_pkg::ST_MUTE;
                end
            ostc_pkg::ST_MUTE:
                state_next = ostc_pkg::ST_HOLD;
            ostc_pkg::ST_HOLD:
                state_next = ostc_pkg::ST_WAIT_RELEASE;
            ostc_pkg::ST_WAIT_RELEASE:
                if (release_ok) begin
                    state_next = ctrl.refsync ? ostc_pkg::ST_OFFSET : ostc_pkg::ST_RELEASE;
                end
            ostc_pkg::ST_OFFSET:
                if (offset_cnt_reg == 2'(`OSTC_REF_OFFSET_CYC - 1)) begin
                    state_next = ostc_pkg::ST_RELEASE;
                end
            ostc_pkg::ST_RELEASE:
                state_next = ostc_pkg::ST_IDLE;
            default:
                state_next = ostc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= ostc_pkg::ST_IDLE;
            pending_reg      <= 1'b0;
            pend_all_reg     <= 1'b0;
            armed            <= 1'b1;
            first_done       <= 1'b0;
            cause_reconf_reg <= 1'b0;
            offset_cnt_reg   <= 2'h0;
        end else begin
            state          <= state_next;
            pending_reg    <= trig || (pending_reg && !start);
            pend_all_reg   <= trig_all || (pend_all_reg && !start);
            armed          <= ctrl.rearm || ctrl.mode_wr || (armed && !auto_fire);
            offset_cnt_reg <= (state == ostc_pkg::ST_OFFSET) ? offset_cnt_reg + 2'h1 : 2'h0;
            if (start) begin
                // The reconfiguration pulse is long gone here, so the cause is kept in pend_all_reg.
                cause_reconf_reg <= !pend_all_reg;
            end
            if (state == ostc_pkg::ST_RELEASE) begin
                first_done <= 1'b1;
            end
        end
    end

    // Everything is muted and held in reset until the first sequence ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_mute  <= {NOUT{1'b1}};
            div_reset <= {NOUT{1'b1}};
        end else if (state == ostc_pkg::ST_MUTE) begin
            out_mute  <= out_mute | affected;
        end else if (state == ostc_pkg::ST_HOLD) begin
            div_reset <= div_reset | affected;
        end else if (state == ostc_pkg::ST_RELEASE) begin
            out_mute  <= out_mute & ~affected;
            div_reset <= div_reset & ~affected;
        end
    end
endmodule : ostc_chan_seq

// ===== core/ostc_map.svh
// Register indices, field positions, reset values and timing for the output sync trigger block.
`ifndef OSTC_MAP_SVH
`define OSTC_MAP_SVH

`define OSTC_IDX_CH0_SYNC_CTRL   14'h10db
`define OSTC_IDX_CH1_SYNC_CTRL   14'h14db
`define OSTC_IDX_CH0_REARM       14'h2107
`define OSTC_IDX_CH1_REARM       14'h2207
`define OSTC_IDX_GLOBAL_MANUAL   14'h2000
`define OSTC_IDX_CH0_MANUAL      14'h2101
`define OSTC_IDX_CH1_MANUAL      14'h2201
`define OSTC_IDX_COMMIT          14'h000f
`define OSTC_IDX_CH0_DIV_BASE    14'h1100
`define OSTC_IDX_CH1_DIV_BASE    14'h1500
`define OSTC_IDX_CH0_SYSCLK_SRC  14'h10dc
`define OSTC_IDX_CH0_SYSCLK_MASK 14'h10dd
`define OSTC_IDX_CH1_SYSCLK_SRC  14'h14dc
`define OSTC_IDX_CH1_SYSCLK_MASK 14'h14dd
`define OSTC_IDX_STATUS          14'h3000

`define OSTC_MODE_LSB            0
`define OSTC_MODE_MSB            1
`define OSTC_REFSYNC_BIT         2
`define OSTC_MANUAL_BIT          3
`define OSTC_REARM_BIT           0
`define OSTC_COMMIT_BIT          0

`define OSTC_SYNC_CTRL_RST       8'h00
`define OSTC_MANUAL_RST          8'h00
`define OSTC_DIV_RST             8'h01
`define OSTC_SYSCLK_RST          8'h00

`define OSTC_CH0_OUTPUTS         6
`define OSTC_CH1_OUTPUTS         4
`define OSTC_DIV_TOTAL           10

`define OSTC_CLK_PERIOD_NS       100
`define OSTC_REF_OFFSET_NS       30
`define OSTC_REF_OFFSET_CYC      (((`OSTC_REF_OFFSET_NS / `OSTC_CLK_PERIOD_NS) < 1) ? 1 : \
                                  (`OSTC_REF_OFFSET_NS / `OSTC_CLK_PERIOD_NS))

`endif

// ===== core/ostc_pkg.sv
// Types shared by the output sync trigger block.
package ostc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_HITLESS,
        ST_MUTE,
        ST_HOLD,
        ST_WAIT_RELEASE,
        ST_OFFSET,
        ST_RELEASE
    } ostc_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic       mode_wr;
        logic       rearm;
        logic       refsync;
        logic       manual;
        logic       reconf;
    } ostc_ctrl_t;

    typedef struct packed {
        logic sys_lock;
        logic phase_lock;
        logic freq_lock;
        logic aml_lock;
        logic hitless;
        logic ref_rise;
    } ostc_lock_t;

endpackage : ostc_pkg

// ===== core/ostc_sync2.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module ostc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : ostc_sync2

// ===== core/ostc_top.sv
// Output sync trigger control: APB registers, ratio change detection and two channel sequencers.
`timescale 1ns/1ps
`include "ostc_map.svh"
module ostc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sysclk_locked,
    input  wire logic [1:0]  digital_loop_phase_lock,
    input  wire logic [1:0]  digital_loop_freq_lock,
    input  wire logic [1:0]  analog_multiplier_loop_cal_lock,
    input  wire logic [1:0]  hitless_profile_active,
    input  wire logic [1:0]  active_ref_clk,
    output logic      [5:0]  channel_zero_out_mute,
    output logic      [5:0]  channel_zero_div_reset,
    output logic      [3:0]  channel_one_out_mute,
    output logic      [3:0]  channel_one_div_reset,
    output logic      [47:0] channel0_output_divider_ratio,
    output logic      [31:0] channel1_output_divider_ratio
);
    localparam int NDIV = `OSTC_DIV_TOTAL;
    localparam int N0   = `OSTC_CH0_OUTPUTS;
    localparam int N1   = `OSTC_CH1_OUTPUTS;

    // Index decode: word aligned addresses only, index is byte address over four.
    function automatic logic hit(input logic [15:0] addr, input logic [13:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[15:2] == idx);
    endfunction : hit

    function automatic logic in_range(input logic [15:0] addr, input logic [13:0] base,
                                      input int n);
        logic [13:0] diff;
        diff     = addr[15:2] - base;
        in_range = (addr[1:0] == 2'h0) && (addr[15:2] >= base) && (diff < 14'(n));
    endfunction : in_range

    // Register state.
    logic [7:0] ch0_sync_ctrl_reg;
    logic [7:0] ch1_sync_ctrl_reg;
    logic [7:0] global_manual_reg;
    logic [7:0] ch0_manual_reg;
    logic [7:0] ch1_manual_reg;
    logic [7:0] ch0_sysclk_src_reg;
    logic [7:0] ch0_sysclk_mask_reg;
    logic [7:0] ch1_sysclk_src_reg;
    logic [7:0] ch1_sysclk_mask_reg;
    logic [7:0] staged_div_reg [NDIV];
    logic [7:0] active_div_reg [NDIV];
    logic [1:0] reconf_reg;

    // Bus decode.
    logic        setup;
    logic        wr_en;
    logic [13:0] widx;
    logic        hit_ctrl0;
    logic        hit_ctrl1;
    logic        hit_rearm0;
    logic        hit_rearm1;
    logic        hit_gman;
    logic        hit_man0;
    logic        hit_man1;
    logic        hit_commit;
    logic        hit_src0;
    logic        hit_mask0;
    logic        hit_src1;
    logic        hit_mask1;
    logic        hit_status;
    logic        hit_div0;
    logic        hit_div1;
    logic        mapped;
    logic        commit;
    logic [3:0]  div_sel;
    logic [31:0] rd_value;
    logic [31:0] status_word;
    logic [NDIV-1:0] div_changed;

    assign setup      = psel && !penable;
    assign wr_en      = psel && penable && pwrite;
    assign widx       = paddr[15:2];
    assign hit_ctrl0  = hit(paddr, `OSTC_IDX_CH0_SYNC_CTRL);
    assign hit_ctrl1  = hit(paddr, `OSTC_IDX_CH1_SYNC_CTRL);
    assign hit_rearm0 = hit(paddr, `OSTC_IDX_CH0_REARM);
    assign hit_rearm1 = hit(paddr, `OSTC_IDX_CH1_REARM);
    assign hit_gman   = hit(paddr, `OSTC_IDX_GLOBAL_MANUAL);
    assign hit_man0   = hit(paddr, `OSTC_IDX_CH0_MANUAL);
    assign hit_man1   = hit(paddr, `OSTC_IDX_CH1_MANUAL);
    assign hit_commit = hit(paddr, `OSTC_IDX_COMMIT);
    assign hit_src0   = hit(paddr, `OSTC_IDX_CH0_SYSCLK_SRC);
    assign hit_mask0  = hit(paddr, `OSTC_IDX_CH0_SYSCLK_MASK);
    assign hit_src1   = hit(paddr, `OSTC_IDX_CH1_SYSCLK_SRC);
    assign hit_mask1  = hit(paddr, `OSTC_IDX_CH1_SYSCLK_MASK);
    assign hit_status = hit(paddr, `OSTC_IDX_STATUS);
    assign hit_div0   = in_range(paddr, `OSTC_IDX_CH0_DIV_BASE, N0);
    assign hit_div1   = in_range(paddr, `OSTC_IDX_CH1_DIV_BASE, N1);
    assign div_sel    = hit_div0 ? 4'(widx - `OSTC_IDX_CH0_DIV_BASE)
                                 : 4'(widx - `OSTC_IDX_CH1_DIV_BASE + 14'(N0));
    assign mapped     = hit_ctrl0 || hit_ctrl1 || hit_rearm0 || hit_rearm1 || hit_gman ||
                        hit_man0 || hit_man1 || hit_commit || hit_src0 || hit_mask0 ||
                        hit_src1 || hit_mask1 || hit_status || hit_div0 || hit_div1;
    assign commit     = wr_en && hit_commit && pwdata[`OSTC_COMMIT_BIT];

    // Zero wait states; unmapped accesses are answered with an error and no effect.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Sequencer side signals.
    ostc_pkg::ostc_ctrl_t  ctrl0;
    ostc_pkg::ostc_ctrl_t  ctrl1;
    ostc_pkg::ostc_lock_t  lock0;
    ostc_pkg::ostc_lock_t  lock1;
    ostc_pkg::ostc_state_t state0;
    ostc_pkg::ostc_state_t state1;
    logic       first_done0;
    logic       first_done1;
    logic       armed0;
    logic       armed1;
    logic       sys_lock_s;
    logic [1:0] phase_s;
    logic [1:0] freq_s;
    logic [1:0] aml_s;
    logic [1:0] hitless_s;
    logic [1:0] ref_s;
    logic [1:0] ref_prev_reg;
    logic [1:0] ref_rise;

    ostc_sync2 #(.W(11)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({sysclk_locked, digital_loop_phase_lock, digital_loop_freq_lock,
                   analog_multiplier_loop_cal_lock, hitless_profile_active, active_ref_clk}),
        .q       ({sys_lock_s, phase_s, freq_s, aml_s, hitless_s, ref_s})
    );

    assign ref_rise = ref_s & ~ref_prev_reg;

    // The comparison covers every divider of a channel, so any one change retimes all but its sysclk-masked outputs.
    generate
        for (genvar i = 0; i < NDIV; i++) begin : g_cmp
            assign div_changed[i] = (staged_div_reg[i] != active_div_reg[i]);
            if (i < N0) begin : g_q0
                assign channel0_output_divider_ratio[8*i +: 8] = active_div_reg[i];
            end else begin : g_q1
                assign channel1_output_divider_ratio[8*(i-N0) +: 8] = active_div_reg[i];
            end
        end
    endgenerate

    assign ctrl0 = '{mode:    ch0_sync_ctrl_reg[`OSTC_MODE_MSB:`OSTC_MODE_LSB],
                     mode_wr: wr_en && hit_ctrl0,
                     rearm:   wr_en && hit_rearm0 && pwdata[`OSTC_REARM_BIT],
                     refsync: ch0_sync_ctrl_reg[`OSTC_REFSYNC_BIT],
                     manual:  global_manual_reg[`OSTC_MANUAL_BIT] ||
                              ch0_manual_reg[`OSTC_MANUAL_BIT],
                     reconf:  reconf_reg[0]};
    assign ctrl1 = '{mode:    ch1_sync_ctrl_reg[`OSTC_MODE_MSB:`OSTC_MODE_LSB],
                     mode_wr: wr_en && hit_ctrl1,
                     rearm:   wr_en && hit_rearm1 && pwdata[`OSTC_REARM_BIT],
                     refsync: ch1_sync_ctrl_reg[`OSTC_REFSYNC_BIT],
                     manual:  global_manual_reg[`OSTC_MANUAL_BIT] ||
                              ch1_manual_reg[`OSTC_MANUAL_BIT],
                     reconf:  reconf_reg[1]};
    assign lock0 = '{sys_lock: sys_lock_s, phase_lock: phase_s[0], freq_lock: freq_s[0],
                     aml_lock: aml_s[0], hitless: hitless_s[0], ref_rise: ref_rise[0]};
    assign lock1 = '{sys_lock: sys_lock_s, phase_lock: phase_s[1], freq_lock: freq_s[1],
                     aml_lock: aml_s[1], hitless: hitless_s[1], ref_rise: ref_rise[1]};

    ostc_chan_seq #(.NOUT(N0)) u_ch0 (
        .pclk       (pclk),
        .presetn    (presetn),
        .ctrl       (ctrl0),
        .lock       (lock0),
        .excl       (ch0_sysclk_src_reg[N0-1:0] & ch0_sysclk_mask_reg[N0-1:0]),
        .out_mute   (channel_zero_out_mute),
        .div_reset  (channel_zero_div_reset),
        .state      (state0),
        .first_done (first_done0),
        .armed      (armed0)
    );

    ostc_chan_seq #(.NOUT(N1)) u_ch1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .ctrl       (ctrl1),
        .lock       (lock1),
        .excl       (ch1_sysclk_src_reg[N1-1:0] & ch1_sysclk_mask_reg[N1-1:0]),
        .out_mute   (channel_one_out_mute),
        .div_reset  (channel_one_div_reset),
        .state      (state1),
        .first_done (first_done1),
        .armed      (armed1)
    );

    assign status_word = {20'h00000, armed1, armed0, first_done1, first_done0,
                          1'b0, 3'(state1), 1'b0, 3'(state0)};

    // Read mux; the re-arm and commit registers read back as zero.
    assign rd_value = hit_ctrl0  ? {24'h000000, ch0_sync_ctrl_reg} :
                      hit_ctrl1  ? {24'h000000, ch1_sync_ctrl_reg} :
                      hit_gman   ? {24'h000000, global_manual_reg} :
                      hit_man0   ? {24'h000000, ch0_manual_reg} :
                      hit_man1   ? {24'h000000, ch1_manual_reg} :
                      hit_src0   ? {24'h000000, ch0_sysclk_src_reg} :
                      hit_mask0  ? {24'h000000, ch0_sysclk_mask_reg} :
                      hit_src1   ? {24'h000000, ch1_sysclk_src_reg} :
                      hit_mask1  ? {24'h000000, ch1_sysclk_mask_reg} :
                      hit_status ? status_word :
                      (hit_div0 || hit_div1) ? {24'h000000, staged_div_reg[div_sel]} :
                      32'h00000000;

    // Read data is captured in the setup cycle and stands through the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= rd_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev_reg <= 2'h0;
        end else begin
            ref_prev_reg <= ref_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch0_sync_ctrl_reg   <= `OSTC_SYNC_CTRL_RST;
            ch1_sync_ctrl_reg   <= `OSTC_SYNC_CTRL_RST;
            global_manual_reg   <= `OSTC_MANUAL_RST;
            ch0_manual_reg      <= `OSTC_MANUAL_RST;
            ch1_manual_reg      <= `OSTC_MANUAL_RST;
            ch0_sysclk_src_reg  <= `OSTC_SYSCLK_RST;
            ch0_sysclk_mask_reg <= `OSTC_SYSCLK_RST;
            ch1_sysclk_src_reg  <= `OSTC_SYSCLK_RST;
            ch1_sysclk_mask_reg <= `OSTC_SYSCLK_RST;
        end else if (wr_en) begin
            if (hit_ctrl0)  ch0_sync_ctrl_reg   <= pwdata[7:0];
            if (hit_ctrl1)  ch1_sync_ctrl_reg   <= pwdata[7:0];
            if (hit_gman)   global_manual_reg   <= pwdata[7:0];
            if (hit_man0)   ch0_manual_reg      <= pwdata[7:0];
            if (hit_man1)   ch1_manual_reg      <= pwdata[7:0];
            if (hit_src0)   ch0_sysclk_src_reg  <= pwdata[7:0];
            if (hit_mask0)  ch0_sysclk_mask_reg <= pwdata[7:0];
            if (hit_src1)   ch1_sysclk_src_reg  <= pwdata[7:0];
            if (hit_mask1)  ch1_sysclk_mask_reg <= pwdata[7:0];
        end
    end

    // Staged ratios take effect only on commit, which is also when a change is judged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NDIV; i++) begin
                staged_div_reg[i] <= `OSTC_DIV_RST;
                active_div_reg[i] <= `OSTC_DIV_RST;
            end
            reconf_reg <= 2'h0;
        end else begin
            if (wr_en && (hit_div0 || hit_div1)) begin
                staged_div_reg[div_sel] <= pwdata[7:0];
            end
            if (commit) begin
                for (int i = 0; i < NDIV; i++) begin
                    active_div_reg[i] <= staged_div_reg[i];
                end
            end
            reconf_reg[0] <= commit && (|div_changed[N0-1:0]);
            reconf_reg[1] <= commit && (|div_changed[NDIV-1:N0]);
        end
    end
endmodule : ostc_top

// ===== verif/ostc_sva.sv
// Port-level assertions for the output sync trigger block.
`timescale 1ns/1ps
module ostc_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pslverr,
    input wire logic       sysclk_locked,
    input wire logic [5:0] channel_zero_out_mute,
    input wire logic [5:0] channel_zero_div_reset,
    input wire logic [3:0] channel_one_out_mute,
    input wire logic [3:0] channel_one_div_reset
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Output 5 is never masked in the bench, so its release marks every sequence end.
    sequence s_unmute0;
        $fell(channel_zero_out_mute[5]);
    endsequence
    a_reset_held: assert property ($rose(presetn) |->
        channel_zero_div_reset == 6'h3f && channel_one_div_reset == 4'hf)
        else $error("dividers not held after reset");
    a_mute_div0: assert property ((channel_zero_div_reset & ~channel_zero_out_mute) == 6'h00)
        else $error("channel 0 divider held while unmuted");
    a_mute_div1: assert property ((channel_one_div_reset & ~channel_one_out_mute) == 4'h0)
        else $error("channel 1 divider held while unmuted");
    a_unmute_all: assert property (s_unmute0 |-> channel_zero_out_mute == 6'h00)
        else $error("channel 0 outputs not released together");
    a_release_div: assert property (s_unmute0 |-> channel_zero_div_reset == 6'h00)
        else $error("channel 0 dividers not released with unmute");
    a_unmute_one: assert property ($fell(channel_one_out_mute[3]) |->
        channel_one_out_mute == 4'h0 && channel_one_div_reset == 4'h0)
        else $error("channel 1 outputs not released together");
    a_lock_first: assert property ($rose(channel_zero_div_reset[5]) |->
        $past(sysclk_locked, 3)) else $error("sequence began without lock");
    a_slverr_phase: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");
endmodule : ostc_sva

bind ostc_top ostc_sva i_sva (.*);

// ===== verif/test_output_sync_trigger_control.sv
// Self-checking bench for the output sync trigger block.
`timescale 1ns/1ps
`include "ostc_map.svh"
module test_output_sync_trigger_control;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sys, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  ph, fr, aml, hit, rf;
    logic [5:0]  m0, d0;
    logic [3:0]  m1, d1;
    logic [47:0] q0;
    logic [31:0] q1;
    int          bad_count, total_checks;
    ostc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysclk_locked(sys), .digital_loop_phase_lock(ph),
        .digital_loop_freq_lock(fr), .analog_multiplier_loop_cal_lock(aml),
        .hitless_profile_active(hit), .active_ref_clk(rf), .channel_zero_out_mute(m0),
        .channel_zero_div_reset(d0), .channel_one_out_mute(m1), .channel_one_div_reset(d1),
        .channel0_output_divider_ratio(q0), .channel1_output_divider_ratio(q1));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= {a, 2'b00}; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    // Polls on the falling edge so registered outputs have settled.
    task automatic wt(input bit ch, input logic [5:0] e);
        logic [5:0] v;
        for (int n = 0; n < 60; n++) begin
            @(negedge pclk);
            v = ch ? {2'b00, m1} : m0;
            if (v === e) break;
        end
        chk(v, e);
    endtask : wt
    task automatic hold(input logic [5:0] e);
        repeat (30) @(negedge pclk);
        chk(m0, e);
    endtask : hold
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #3000000;
        bad_count++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sys, ph, fr, rf} = '0;
        aml = 2'b11; hit = 2'b11; presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({m0, m1, d0, d1}, 20'hfffff);
        apb(1'b0, `OSTC_IDX_CH0_SYNC_CTRL, 0); chk(r, 0);
        apb(1'b0, 14'h0100, 0); chk({r, err}, 33'h1);
        sys <= 1'b1;
        wr(`OSTC_IDX_CH0_DIV_BASE, 8'h04); wr(`OSTC_IDX_COMMIT, 8'h01);
        hold(6'h3f); chk(q0[7:0], 8'h04);
        wr(`OSTC_IDX_CH0_SYNC_CTRL, 8'h02); wr(`OSTC_IDX_CH1_SYNC_CTRL, 8'h03);
        hold(6'h3f); chk(m1, 4'hf);
        @(posedge pclk);
        ph <= 2'b01; fr <= 2'b10;
        wt(0, 6'h00); wt(1, 6'h00);
        hold(6'h00);
        wr(`OSTC_IDX_CH0_REARM, 8'h01); wt(0, 6'h3f); wt(0, 6'h00);
        wr(`OSTC_IDX_CH1_SYNC_CTRL, 8'h01); wt(1, 6'h0f); wt(1, 6'h00);
        wr(`OSTC_IDX_CH1_DIV_BASE + 14'h3, 8'h07); wr(`OSTC_IDX_COMMIT, 8'h01);
        wt(1, 6'h0f); wt(1, 6'h00); chk(q1[31:24], 8'h07);
        wr(`OSTC_IDX_CH0_SYSCLK_SRC, 8'h01); wr(`OSTC_IDX_CH0_SYSCLK_MASK, 8'h01);
        wr(`OSTC_IDX_CH0_DIV_BASE + 14'h2, 8'h09); wr(`OSTC_IDX_COMMIT, 8'h01);
        wt(0, 6'h3e); wt(0, 6'h00);
        wr(`OSTC_IDX_CH0_MANUAL, 8'h08); wt(0, 6'h3f); hold(6'h3f); chk(d0, 6'h3f);
        @(posedge pclk);
        aml <= 2'b10;
        wr(`OSTC_IDX_CH0_MANUAL, 8'h00); hold(6'h3f);
        @(posedge pclk);
        aml <= 2'b11;
        wt(0, 6'h00); chk({d0, d1}, 10'h000);
        wr(`OSTC_IDX_CH0_SYNC_CTRL, 8'h04); wr(`OSTC_IDX_COMMIT, 8'h01);
        wr(`OSTC_IDX_CH0_SYNC_CTRL, 8'h06);
        apb(1'b0, `OSTC_IDX_CH0_SYNC_CTRL, 0); chk(r, 32'h6);
        wt(0, 6'h3f); hold(6'h3f);
        @(posedge pclk);
        hit <= 2'b10; rf <= 2'b01;
        hold(6'h3f);
        @(posedge pclk);
        hit <= 2'b11; rf <= 2'b00;
        hold(6'h3f);
        @(posedge pclk);
        rf <= 2'b01;
        wt(0, 6'h00);
        finish_test();
    end
endmodule : test_output_sync_trigger_control
